// ### rtl/spi_audio_error_control.sv
/*
  Serial audio / SPI slave with error-control register, APB slave, sticky
  event status with mask and interrupt, one-word receive and transmit buffers.
  Assumes sck, frame_sel and sdi come from outside the clk domain and are far
  slower than clk; frame_sel is slave select (low active) in plain SPI mode and
  word select / frame sync in audio mode.
*/
// Decided for this implementation: register access over APB and the placing of the registers.
// Function
// - sign setting one: receive word read back sign-extended to 32 bits
// - frame error raises error event only while its enable is one
// - receive overflow raises error event only while its enable is one
// - transmit underrun raises error event only while its enable is one
// - ignore-overflow one: overflow not critical, held receive word kept
// - ignore-overflow zero: overflow halts serial operation
// - ignore-underrun one: underrun not critical, zero words shifted out
// - ignore-underrun zero: underrun halts serial operation
// - audio enable selects audio framing, else plain SPI framing
// - mono: each transmit word sent in left and right slots
// - protocol select: 11 PCM, 10 right, 01 left justified, 00 I2S
// - audio enable, mono, protocol fields writable only while module disabled
// - mono and protocol select ignored unless audio enabled
// - unimplemented control bits and upper half read as zero
`timescale 1ns/1ns
`default_nettype none

module spi_audio_error_control (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        sck,
  input  wire logic        frame_sel,
  input  wire logic        sdi,
  output var  logic        sdo,
  output var  logic        irq,
  output var  logic        error_event
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0]                 ctrl_r;
  logic                        module_en_r;
  logic [2:0]                  status_r;
  logic [2:0]                  mask_r;
  logic [15:0]                 tx_buf_r;
  logic                        tx_full_r;
  logic [15:0]                 rx_buf_r;
  logic                        rx_full_r;
  logic [15:0]                 mono_word_r;
  logic                        halted_r;
  spi_audio_pkg::link_state_e  state_r;
  spi_audio_pkg::link_state_e  state_nxt;
  logic [3:0]                  bit_cnt_r;
  logic [15:0]                 rx_shift_r;
  logic [15:0]                 tx_shift_r;
  logic                        shift_pend_r;
  logic                        slot_r;
  logic [2:0]                  sck_q;
  logic [2:0]                  fs_q;
  logic [1:0]                  sdi_q;
  logic [31:0]                 prdata_r;
  logic                        irq_r;
  logic                        error_event_r;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire apb_setup  = psel & ~penable;
  wire apb_access = psel & penable;
  wire apb_wr     = apb_access & pwrite;
  wire apb_rd     = apb_access & ~pwrite;
  wire hit_audio  = paddr == spi_audio_pkg::AUDIO_CTRL_OFS;
  wire hit_module = paddr == spi_audio_pkg::MODULE_CTRL_OFS;
  wire hit_status = paddr == spi_audio_pkg::STATUS_OFS;
  wire hit_mask   = paddr == spi_audio_pkg::MASK_OFS;
  wire hit_tx     = paddr == spi_audio_pkg::TX_DATA_OFS;
  wire hit_rx     = paddr == spi_audio_pkg::RX_DATA_OFS;
  wire mapped     = hit_audio | hit_module | hit_status | hit_mask | hit_tx | hit_rx;
  wire rx_pop     = apb_rd & hit_rx;
  wire tx_push    = apb_wr & hit_tx;

  // locked audio fields take writes only while the module is off
  wire [15:0] ctrl_wmask = module_en_r ? spi_audio_pkg::AUDIO_FREE_MASK
                                       : (spi_audio_pkg::AUDIO_FREE_MASK | spi_audio_pkg::AUDIO_LOCK_MASK);
  wire [15:0] ctrl_nxt   = (apb_wr & hit_audio) ? ((ctrl_r & ~ctrl_wmask) | (pwdata[15:0] & ctrl_wmask)) : ctrl_r;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  wire aud_en     = ctrl_r[spi_audio_pkg::AUD_EN_BIT];
  wire mono_eff   = aud_en & ctrl_r[spi_audio_pkg::MONO_BIT];
  wire [1:0] mode_sel = ctrl_r[spi_audio_pkg::MODE_LSB +: 2];
  wire mode_pcm   = aud_en & (mode_sel == spi_audio_pkg::MODE_PCM);
  wire mode_i2s   = aud_en & (mode_sel == spi_audio_pkg::MODE_I2S);
  wire sign_ext   = ctrl_r[spi_audio_pkg::SIGN_EXT_BIT];
  wire ign_ov     = ctrl_r[spi_audio_pkg::IGN_OV_BIT];
  wire ign_ur     = ctrl_r[spi_audio_pkg::IGN_UR_BIT];
  wire [2:0] evt_en = {ctrl_r[spi_audio_pkg::UR_EN_BIT], ctrl_r[spi_audio_pkg::OV_EN_BIT],
                       ctrl_r[spi_audio_pkg::FE_EN_BIT]};

  // ----------------------------------------------------------------
  // link edges and framing
  // ----------------------------------------------------------------
  wire sck_rise = sck_q[1] & ~sck_q[2];
  wire sck_fall = ~sck_q[1] & sck_q[2];
  wire fs_rise  = fs_q[1] & ~fs_q[2];
  wire fs_fall  = ~fs_q[1] & fs_q[2];
  wire fs_level = fs_q[1];
  wire running  = module_en_r & ~halted_r;
  wire start_edge = aud_en ? (mode_pcm ? fs_rise : (fs_rise | fs_fall)) : fs_fall;
  wire start_ev   = running & start_edge;
  wire word_done  = (state_r == spi_audio_pkg::LINK_SHIFT) & sck_rise & (bit_cnt_r == spi_audio_pkg::LAST_BIT);
  // pcm: right slot follows the left one once, then wait for the next sync
  wire restart    = running & word_done & (aud_en ? (mode_pcm & ~slot_r) : ~fs_level);
  wire load       = start_ev | restart;
  // slot: 0 left, 1 right; pcm carries both slots after one sync pulse
  wire load_slot  = start_ev ? (aud_en & ~mode_pcm & fs_level) : aud_en;
  wire reuse      = mono_eff & load_slot;
  wire tx_avail   = reuse | tx_full_r;
  wire tx_pop     = load & ~reuse & tx_full_r;
  wire [15:0] load_word = reuse ? mono_word_r : (tx_full_r ? tx_buf_r : 16'h0000);
  wire [15:0] rx_word   = {rx_shift_r[14:0], sdi_q[1]};

  // ----------------------------------------------------------------
  // error sources
  // ----------------------------------------------------------------
  // only a word with bits already shifted can be cut short
  wire busy  = (state_r != spi_audio_pkg::LINK_IDLE) & (bit_cnt_r != 4'h0);
  wire fe_ev = running & busy & ~word_done & (aud_en ? start_edge : fs_rise);
  wire ov_ev = running & word_done & rx_full_r;
  wire ur_ev = load & ~tx_avail;
  wire halt_now = (ov_ev & ~ign_ov) | (ur_ev & ~ign_ur);
  wire [2:0] evt = {ur_ev, ov_ev, fe_ev};
  wire evt_gated = |(evt & evt_en);
  wire [2:0] status_clr = (apb_wr & hit_status) ? pwdata[2:0] : 3'h0;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [31:0] rx_ext = sign_ext ? {{16{rx_buf_r[15]}}, rx_buf_r} : {16'h0000, rx_buf_r};
  wire [31:0] module_rd = {21'h000000, halted_r, tx_full_r, rx_full_r, 7'h00, module_en_r};
  wire [31:0] read_mux =
    hit_audio  ? {16'h0000, ctrl_r} :
    hit_module ? module_rd :
    hit_status ? {29'h00000000, status_r} :
    hit_mask   ? {29'h00000000, mask_r} :
    hit_tx     ? {16'h0000, tx_buf_r} :
    hit_rx     ? rx_ext : 32'h00000000;

  assign prdata      = prdata_r;
  assign pready      = 1'b1;
  assign pslverr     = apb_access & ~mapped;
  assign sdo         = tx_shift_r[15];
  assign irq         = irq_r;
  assign error_event = error_event_r;

  // ----------------------------------------------------------------
  // link state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    if (~running | halt_now)
      state_nxt = spi_audio_pkg::LINK_IDLE;
    else if (load)
      state_nxt = (start_ev & mode_i2s) ? spi_audio_pkg::LINK_DELAY : spi_audio_pkg::LINK_SHIFT;
    else if (~aud_en & fs_rise)
      state_nxt = spi_audio_pkg::LINK_IDLE;
    else
    begin
      unique case (state_r)
        spi_audio_pkg::LINK_IDLE:  state_nxt = spi_audio_pkg::LINK_IDLE;
        spi_audio_pkg::LINK_DELAY: if (sck_rise) state_nxt = spi_audio_pkg::LINK_SHIFT;
        spi_audio_pkg::LINK_SHIFT: if (word_done) state_nxt = spi_audio_pkg::LINK_IDLE;
        default:                   state_nxt = spi_audio_pkg::LINK_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sck_q <= 3'h0;
      fs_q  <= 3'h7;
      sdi_q <= 2'h0;
    end
    else
    begin
      sck_q <= {sck_q[1:0], sck};
      fs_q  <= {fs_q[1:0], frame_sel};
      sdi_q <= {sdi_q[0], sdi};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ctrl_r      <= spi_audio_pkg::AUDIO_CTRL_RST;
      module_en_r <= 1'b0;
      mask_r      <= spi_audio_pkg::EVT_RST;
      status_r    <= spi_audio_pkg::EVT_RST;
    end
    else
    begin
      ctrl_r      <= ctrl_nxt;
      module_en_r <= (apb_wr & hit_module) ? pwdata[spi_audio_pkg::MODULE_EN_BIT] : module_en_r;
      mask_r      <= (apb_wr & hit_mask) ? pwdata[2:0] : mask_r;
      status_r    <= evt | (status_r & ~status_clr);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      prdata_r      <= 32'h00000000;
      irq_r         <= 1'b0;
      error_event_r <= 1'b0;
      halted_r      <= 1'b0;
    end
    else
    begin
      prdata_r      <= apb_setup ? read_mux : prdata_r;
      irq_r         <= |(status_r & mask_r);
      error_event_r <= evt_gated;
      halted_r      <= module_en_r & (halted_r | halt_now);
    end
  end

  // ----------------------------------------------------------------
  // buffers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      tx_buf_r    <= 16'h0000;
      tx_full_r   <= 1'b0;
      rx_buf_r    <= 16'h0000;
      rx_full_r   <= 1'b0;
      mono_word_r <= 16'h0000;
      slot_r      <= 1'b0;
    end
    else
    begin
      tx_buf_r    <= tx_push ? pwdata[15:0] : tx_buf_r;
      tx_full_r   <= tx_push | (tx_full_r & ~tx_pop);
      // held word is never overwritten while full
      rx_buf_r    <= (word_done & running & ~rx_full_r) ? rx_word : rx_buf_r;
      rx_full_r   <= (word_done & running & ~rx_full_r) | (rx_full_r & ~rx_pop);
      mono_word_r <= (load & ~reuse) ? load_word : mono_word_r;
      slot_r      <= load ? load_slot : slot_r;
    end
  end

  // ----------------------------------------------------------------
  // shifter
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_r      <= spi_audio_pkg::LINK_IDLE;
      bit_cnt_r    <= 4'h0;
      rx_shift_r   <= 16'h0000;
      tx_shift_r   <= 16'h0000;
      shift_pend_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (load)
      begin
        bit_cnt_r    <= 4'h0;
        tx_shift_r   <= load_word;
        shift_pend_r <= 1'b0;
      end
      else if ((state_r == spi_audio_pkg::LINK_SHIFT) & sck_rise)
      begin
        bit_cnt_r    <= bit_cnt_r + 4'h1;
        rx_shift_r   <= rx_word;
        shift_pend_r <= 1'b1;
      end
      else if (sck_fall & shift_pend_r)
      begin
        tx_shift_r   <= {tx_shift_r[14:0], 1'b0};
        shift_pend_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_SIGN_EXT: assert property (apb_setup && hit_rx && sign_ext && rx_buf_r[15] |=> prdata[31:16] == 16'hFFFF)
    else $error("receive word not sign-extended");
  AST_FE_EVENT: assert property (fe_ev |=> error_event == ($past(evt_en[0]) | $past(ov_ev & evt_en[1]) | $past(ur_ev & evt_en[2])))
    else $error("frame error event gating wrong");
  AST_OV_EVENT: assert property (ov_ev && evt_en[1] |=> error_event)
    else $error("overflow did not raise error event");
  AST_UR_EVENT: assert property (ur_ev && evt_en[2] |=> error_event)
    else $error("underrun did not raise error event");
  AST_OV_KEEP: assert property (ov_ev && ign_ov && !(ur_ev && !ign_ur) |=> rx_buf_r == $past(rx_buf_r) && !halted_r)
    else $error("ignored overflow disturbed held word or halted");
  AST_OV_HALT: assert property (ov_ev && !ign_ov |=> halted_r && state_r == spi_audio_pkg::LINK_IDLE)
    else $error("overflow did not halt");
  AST_UR_ZERO: assert property (ur_ev && ign_ur && !(ov_ev && !ign_ov) |=> tx_shift_r == 16'h0000 && !halted_r)
    else $error("underrun did not send zeros");
  AST_UR_HALT: assert property (ur_ev && !ign_ur |=> halted_r)
    else $error("underrun did not halt");
  AST_LOCKED: assert property (apb_wr && hit_audio && module_en_r |=> (ctrl_r & spi_audio_pkg::AUDIO_LOCK_MASK) == $past(ctrl_r & spi_audio_pkg::AUDIO_LOCK_MASK))
    else $error("locked audio field changed while enabled");
  AST_UPPER_ZERO: assert property (apb_setup && hit_audio |=> prdata[31:16] == 16'h0000 && prdata[14:13] == 2'h0)
    else $error("unimplemented control bits not zero");
  AST_NO_EVENT: assert property (!evt_gated |=> !error_event)
    else $error("error event without enabled source");

  COV_WORD: cover property (word_done && !rx_full_r);
  COV_OVERFLOW: cover property (ov_ev && ign_ov);
  COV_UNDERRUN_HALT: cover property (ur_ev && !ign_ur);
  COV_MONO: cover property (load && reuse);

endmodule

`default_nettype wire

// ### rtl/spi_audio_pkg.sv
/*
  Constants, register map and types of the serial audio error-control block.
  Assumes a 32-bit APB master and a single 100 MHz peripheral clock.
*/
`default_nettype none

package spi_audio_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CNT_W  = 4;
  localparam int unsigned EVT_W  = 3;
  localparam logic [CNT_W-1:0] LAST_BIT = 4'hF;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] AUDIO_CTRL_OFS  = 8'h00;
  localparam logic [ADDR_W-1:0] MODULE_CTRL_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFS      = 8'h08;
  localparam logic [ADDR_W-1:0] MASK_OFS        = 8'h0C;
  localparam logic [ADDR_W-1:0] TX_DATA_OFS     = 8'h10;
  localparam logic [ADDR_W-1:0] RX_DATA_OFS     = 8'h14;

  // ----------------------------------------------------------------
  // serial_audio_control fields
  // ----------------------------------------------------------------
  localparam int unsigned SIGN_EXT_BIT = 15;
  localparam int unsigned FE_EN_BIT    = 12;
  localparam int unsigned OV_EN_BIT    = 11;
  localparam int unsigned UR_EN_BIT    = 10;
  localparam int unsigned IGN_OV_BIT   = 9;
  localparam int unsigned IGN_UR_BIT   = 8;
  localparam int unsigned AUD_EN_BIT   = 7;
  localparam int unsigned MONO_BIT     = 3;
  localparam int unsigned MODE_LSB     = 0;
  localparam logic [WORD_W-1:0] AUDIO_FREE_MASK = 16'h9F00;
  localparam logic [WORD_W-1:0] AUDIO_LOCK_MASK = 16'h008B;
  localparam logic [WORD_W-1:0] AUDIO_CTRL_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // module control and status fields
  // ----------------------------------------------------------------
  localparam int unsigned MODULE_EN_BIT = 0;
  localparam int unsigned RX_FULL_BIT   = 8;
  localparam int unsigned TX_FULL_BIT   = 9;
  localparam int unsigned HALTED_BIT    = 10;
  localparam int unsigned EVT_FE        = 0;
  localparam int unsigned EVT_OV        = 1;
  localparam int unsigned EVT_UR        = 2;
  localparam logic [EVT_W-1:0] EVT_RST  = 3'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_I2S   = 2'b00,
    MODE_LEFT  = 2'b01,
    MODE_RIGHT = 2'b10,
    MODE_PCM   = 2'b11
  } audio_mode_e;

  typedef enum logic [1:0] {
    LINK_IDLE  = 2'b00,
    LINK_DELAY = 2'b01,
    LINK_SHIFT = 2'b11
  } link_state_e;

endpackage

`default_nettype wire

// ### tb/spi_peer.sv
/*
  Behavioural serial peer: drives bit clock, frame select and data in, and
  captures data out. Assumes the device samples on rising bit clock edges and
  shifts out on falling ones; the bit clock stands still outside words.
*/
`timescale 1ns/1ns
`default_nettype none

module spi_peer (
  output var  logic sck,
  output var  logic frame_sel,
  input  wire logic sdo,
  output var  logic sdi
);
  localparam int HALF = 80;

  initial
  begin
    sck = 1'h0;
    frame_sel = 1'h1;
    sdi = 1'h0;
  end

  // frame edge, then settle time for the word load
  task automatic set_fs(input logic lvl);
    #(3*HALF+3);
    frame_sel = lvl;
    #(3*HALF);
  endtask

  // n bits msb first; skip adds one leading bit clock
  task automatic shift(input logic [15:0] d, input int n, input logic skip, output logic [15:0] got);
    got = 16'h0;
    if (skip)
    begin
      #HALF sck = 1'h1;
      #HALF sck = 1'h0;
    end
    for (int i = 0; i < n; i++)
    begin
      sdi = d[15-i];
      #HALF sck = 1'h1;
      got = {got[14:0], sdo};
      #HALF sck = 1'h0;
    end
    // released line must not show the last bit
    sdi = ~sdi;
  endtask
endmodule

`default_nettype wire

// ### tb/test_spi_audio_error_control.sv
/*
  Self-checking bench of the serial audio error-control block.
  Assumes the APB slave answers per its pready and a peer model on the link.
*/
`timescale 1ns/1ns
`default_nettype none

module test_spi_audio_error_control;
  localparam logic [7:0] CTRL = spi_audio_pkg::AUDIO_CTRL_OFS;
  localparam logic [7:0] MODC = spi_audio_pkg::MODULE_CTRL_OFS;
  localparam logic [7:0] STAT = spi_audio_pkg::STATUS_OFS;
  localparam logic [7:0] MSK  = spi_audio_pkg::MASK_OFS;
  localparam logic [7:0] TXD  = spi_audio_pkg::TX_DATA_OFS;
  localparam logic [7:0] RXD  = spi_audio_pkg::RX_DATA_OFS;
  localparam logic [31:0] SX = 32'h8000, FE = 32'h1000, OV = 32'h800, UR = 32'h400;
  localparam logic [31:0] IOV = 32'h200, IUR = 32'h100, AUD = 32'h80, MONO = 32'h8;
  localparam logic [31:0] HALT = 32'h400, RXF = 32'h100;

  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic        sck, frame_sel, sdi, sdo, irq, error_event, e, pre;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, v;
  logic [15:0] w, w2, got;
  int          n_mismatch = 0, num_checks = 0, ev_n = 0, n0;

  spi_audio_error_control dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck(sck),
    .frame_sel(frame_sel), .sdi(sdi), .sdo(sdo), .irq(irq), .error_event(error_event));
  spi_peer peer (.sck(sck), .frame_sel(frame_sel), .sdo(sdo), .sdi(sdi));

  initial clk = 1'h0;
  always #5 clk = ~clk;
  always @(posedge clk)
    if (error_event === 1'h1)
      ev_n <= ev_n + 1;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_reg(input string nm, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [15:0] x, input logic [15:0] g);
    chk_reg(nm, {16'h0, x}, {16'h0, g});
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    int i;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (pready === 1'h1)
        break;
    end
    if (i == 20)
    begin
      n_mismatch++;
      $display("BAD pready expected 1 seen timeout");
      end_sim();
    end
    r = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        er;
    apb(1'h1, a, d, r, er);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic er;
    apb(1'h0, a, 32'h0, r, er);
  endtask

  task automatic spi_word(input logic [15:0] d, input int n, output logic [15:0] g);
    peer.set_fs(1'h0);
    peer.shift(d, n, 1'h0, g);
    peer.set_fs(1'h1);
  endtask

  initial
  begin
    rst_b = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    void'($urandom(54));
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    rd(CTRL, v);
    chk_reg("ctrl reset", 32'h0, v);
    apb(1'h0, 8'h18, 32'h0, v, e);
    chk_reg("unmapped err", 32'h1, {31'h0, e});
    wr(CTRL, 32'hFFFFFFFF);
    rd(CTRL, v);
    chk_reg("ctrl ones", 32'h9F8B, v);
    wr(MODC, 32'h1);
    wr(CTRL, 32'h0);
    rd(CTRL, v);
    chk_reg("ctrl locked", 32'h8B, v);
    wr(MODC, 32'h0);
    wr(CTRL, 32'h0);
    rd(CTRL, v);
    chk_reg("ctrl cleared", 32'h0, v);
    $display("test registers done");
    for (int s = 0; s < 2; s++)
    begin
      w = 16'($urandom) | 16'h8000;
      w2 = 16'($urandom);
      wr(CTRL, (s ? SX : 32'h0) | MONO | 32'h3 | IUR | IOV);
      wr(TXD, {16'h0, w2});
      wr(MODC, 32'h1);
      spi_word(w, 16, got);
      chk_word("sdo word", w2, got);
      rd(RXD, v);
      chk_reg("rx word", s ? {16'hFFFF, w} : {16'h0, w}, v);
      rd(STAT, v);
      chk_reg("clean frame", 32'h0, v & 32'h1);
      wr(MODC, 32'h0);
    end
    $display("test plain transfer done");
    for (int en = 0; en < 2; en++)
    begin
      wr(CTRL, IUR | IOV | (en ? UR : 32'h0));
      wr(STAT, 32'h7);
      wr(MODC, 32'h1);
      n0 = ev_n;
      spi_word(16'($urandom), 16, got);
      chk_word("underrun zeros", 16'h0, got);
      rd(STAT, v);
      chk_reg("underrun flag", 32'h4, v & 32'h4);
      chk_reg("underrun event", 32'(en), 32'(ev_n != n0));
      rd(MODC, v);
      chk_reg("underrun halt", 32'h0, v & HALT);
      rd(RXD, v);
      wr(MODC, 32'h0);
    end
    w = 16'($urandom);
    w2 = 16'($urandom);
    wr(CTRL, IUR | IOV | OV);
    wr(STAT, 32'h7);
    wr(MODC, 32'h1);
    n0 = ev_n;
    spi_word(w, 16, got);
    spi_word(w2, 16, got);
    rd(STAT, v);
    chk_reg("overflow flag", 32'h2, v & 32'h2);
    chk_reg("overflow event", 32'h1, 32'(ev_n != n0));
    rd(MODC, v);
    chk_reg("overflow halt", 32'h0, v & HALT);
    rd(RXD, v);
    chk_reg("rx kept", {16'h0, w}, v);
    wr(MODC, 32'h0);
    wr(CTRL, IUR);
    wr(MODC, 32'h1);
    n0 = ev_n;
    spi_word(w, 16, got);
    spi_word(w2, 16, got);
    rd(MODC, v);
    chk_reg("overflow halted", HALT, v & HALT);
    chk_reg("overflow no event", 32'h0, 32'(ev_n != n0));
    rd(RXD, v);
    spi_word(w, 16, got);
    rd(MODC, v);
    chk_reg("halted rx", 32'h0, v & RXF);
    wr(MODC, 32'h0);
    wr(CTRL, IOV);
    wr(MODC, 32'h1);
    spi_word(w, 16, got);
    rd(MODC, v);
    chk_reg("underrun halted", HALT, v & HALT);
    wr(MODC, 32'h0);
    $display("test overflow underrun done");
    for (int en = 0; en < 2; en++)
    begin
      wr(CTRL, IUR | IOV | (en ? FE : 32'h0));
      wr(STAT, 32'h7);
      wr(TXD, 32'($urandom) & 32'hFFFF);
      wr(MODC, 32'h1);
      n0 = ev_n;
      spi_word(16'($urandom), 8, got);
      rd(STAT, v);
      chk_reg("frame flag", 32'h1, v & 32'h1);
      chk_reg("frame event", 32'(en), 32'(ev_n != n0));
      wr(MODC, 32'h0);
    end
    wr(MSK, 32'h1);
    rd(MSK, v);
    chk_reg("irq raised", 32'h1, {31'h0, irq});
    wr(MSK, 32'h0);
    rd(MSK, v);
    chk_reg("irq masked", 32'h0, {31'h0, irq});
    wr(MSK, 32'h1);
    wr(STAT, 32'h7);
    rd(STAT, v);
    chk_reg("irq cleared", 32'h0, {31'h0, irq});
    $display("test events done");
    for (int m = 1; m < 4; m++)
    begin
      wr(CTRL, AUD | MONO | 32'(m) | IUR | IOV);
      pre = (m != 3);
      peer.set_fs(pre);
      w = 16'($urandom);
      wr(TXD, {16'h0, w});
      wr(MODC, 32'h1);
      peer.set_fs(!pre);
      peer.shift(~w, 16, 1'h0, got);
      chk_word("mono left", w, got);
      peer.set_fs(pre);
      peer.shift(w, 16, 1'h0, got);
      chk_word("mono right", w, got);
      wr(MODC, 32'h0);
    end
    wr(CTRL, AUD | IUR | IOV);
    peer.set_fs(1'h1);
    w = 16'($urandom);
    w2 = 16'($urandom);
    wr(TXD, {16'h0, w});
    wr(MODC, 32'h1);
    peer.set_fs(1'h0);
    peer.shift(w2, 16, 1'h1, got);
    chk_word("stereo left", w, got);
    wr(TXD, {16'h0, w2});
    peer.set_fs(1'h1);
    peer.shift(w, 16, 1'h1, got);
    chk_word("stereo right", w2, got);
    $display("test audio done");
    end_sim();
  end
endmodule

`default_nettype wire
